// *** iwu_core_model.sv ***
// Purpose: Core stand-in issuing instruction strobes and running handlers
// Assumes: opReq codes 1 sw, 2 enable, 3 disable, 4 clear watchdog
// Notes:   A handler ends with its return after HANDLER_CYC cycles
`timescale 1ns/1ps
module iwu_core_model
   import iwu_pkg::*;
#(
   parameter int HANDLER_CYC = 12
) (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic        stall,
   input  wire logic [2:0]  opReq,
   input  wire logic        vectorValid,
   input  wire logic [10:0] vectorAddr,
   output logic             instrBoundary,
   output logic             swIrqInstr,
   output logic             enableIrqInstr,
   output logic             disableIrqInstr,
   output logic             returnIrqInstr,
   output logic             clearWatchdogInstr,
   output logic      [10:0] lastVector,
   output logic      [7:0]  vecCount
);
   logic [4:0] handlerCnt;
   // Boundary every cycle unless stalled
   assign instrBoundary = ~stall;
   // Strobes, vector capture and handler run
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         {swIrqInstr, enableIrqInstr, disableIrqInstr} <= 3'h0;
         {returnIrqInstr, clearWatchdogInstr} <= 2'h0;
         lastVector <= 11'h000;
         vecCount <= 8'h00;
         handlerCnt <= 5'h00;
      end else begin
         swIrqInstr <= (opReq == 3'h1);
         enableIrqInstr <= (opReq == 3'h2);
         disableIrqInstr <= (opReq == 3'h3);
         clearWatchdogInstr <= (opReq == 3'h4);
         returnIrqInstr <= (handlerCnt == 5'h01); // Last op, no enable before it
         if (vectorValid) begin
            lastVector <= vectorAddr;
            vecCount <= vecCount + 8'h01;
            handlerCnt <= 5'(HANDLER_CYC);
         end else if (handlerCnt != 5'h00) begin
            handlerCnt <= handlerCnt - 5'h01;
         end
      end
   end
endmodule // iwu_core_model

// *** iwu_pkg.sv ***
// Purpose: Shared constants for the interrupt and watchdog unit
// Assumes: 100 MHz core clock
// Notes:   APB register map, field positions, vectors, timer wrap-from values, timing
package iwu_pkg;
   // -------------------------------------------------------------
   // Register offsets (byte addresses)
   // -------------------------------------------------------------
   localparam logic [7:0] IWU_FLAG_OFF    = 8'h00; // irq_flag_reg
   localparam logic [7:0] IWU_ENABLE_OFF  = 8'h04; // irq_enable_reg
   localparam logic [7:0] IWU_POWER_CONTROL_REG_OFF    = 8'h08; // power_control_reg
   localparam logic [7:0] IWU_STATUS_OFF  = 8'h0c; // status, timeout indicator
   localparam logic [7:0] IWU_PRESC_OFF   = 8'h10; // prescaler control
   localparam logic [7:0] IWU_WAKE_OFF    = 8'h14; // wake selects
   localparam logic [7:0] IWU_EXTCFG_OFF  = 8'h18; // external pin config
   localparam logic [7:0] IWU_OSC_OFF     = 8'h1c; // oscillator_control_reg
   // -------------------------------------------------------------
   // Flag and enable bit positions
   // -------------------------------------------------------------
   localparam int IWU_B_TMRA = 0;
   localparam int IWU_B_TMRB = 1;
   localparam int IWU_B_TMRC = 2;
   localparam int IWU_B_TMRD = 3;
   localparam int IWU_B_PORT = 4;
   localparam int IWU_B_EXT0 = 5;
   localparam int IWU_B_WDOG = 6;
   localparam int IWU_B_EXT1 = 7;
   localparam int IWU_B_LOWV = 8;
   localparam int IWU_B_CMP  = 9;
   localparam int IWU_B_CONV = 10;
   localparam int IWU_NSRC   = 11;
   localparam int IWU_B_RUN  = 7;  // watchdog_run_bit in power_control_reg
   localparam int IWU_B_TO   = 4;  // timeout_indicator in status
   // -------------------------------------------------------------
   // Vectors and timer wrap-from values
   // -------------------------------------------------------------
   localparam logic [10:0] IWU_SW_VECTOR = 11'h001;
   localparam logic [10:0] IWU_HW_VECTOR = 11'h008;
   localparam logic [7:0]  IWU_TMR8_WRAP_FROM = 8'h00;
   localparam logic [9:0]  IWU_TMR10_WRAP_FROM = 10'h3ff;
   // -------------------------------------------------------------
   // Watchdog base periods, in microseconds (3.5, 15, 60, 250 ms)
   // -------------------------------------------------------------
   localparam int IWU_CLK_MHZ = 100;
   localparam int IWU_WDT_US0 = 3500;
   localparam int IWU_WDT_US1 = 15000;
   localparam int IWU_WDT_US2 = 60000;
   localparam int IWU_WDT_US3 = 250000;
   localparam int IWU_WDT_CYC0 = IWU_WDT_US0 * IWU_CLK_MHZ;
   localparam int IWU_WDT_CYC1 = IWU_WDT_US1 * IWU_CLK_MHZ;
   localparam int IWU_WDT_CYC2 = IWU_WDT_US2 * IWU_CLK_MHZ;
   localparam int IWU_WDT_CYC3 = IWU_WDT_US3 * IWU_CLK_MHZ;
endpackage

// *** iwu_unit.sv ***
// Purpose: Interrupt flags, vectoring and watchdog of a small 8-bit core
// Assumes: Core gives one-cycle instruction strobes and an instruction boundary
// Notes:   Registers on APB; event inputs from pins are synchronised here
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module iwu_unit
   import iwu_pkg::*;
#(
   parameter int WDT_CYC0 = IWU_WDT_CYC0,
   parameter int WDT_CYC1 = IWU_WDT_CYC1,
   parameter int WDT_CYC2 = IWU_WDT_CYC2,
   parameter int WDT_CYC3 = IWU_WDT_CYC3
) (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Configuration words
   input  wire logic        cfgWdtEnable,
   input  wire logic        cfgWdtIrqMode,
   input  wire logic [1:0]  cfgWdtPeriod,
   // Core instruction strobes
   input  wire logic        instrBoundary,
   input  wire logic        swIrqInstr,
   input  wire logic        enableIrqInstr,
   input  wire logic        disableIrqInstr,
   input  wire logic        returnIrqInstr,
   input  wire logic        clearWatchdogInstr,
   // Same-clock event sources
   input  wire logic [7:0]  timerACount,
   input  wire logic [9:0]  timerBCount,
   input  wire logic [9:0]  timerCCount,
   input  wire logic [9:0]  timerDCount,
   input  wire logic        converterDone,
   // Asynchronous pins
   input  wire logic [7:0]  portAPins,
   input  wire logic [5:0]  portBPins,
   input  wire logic [7:0]  portADirIn,
   input  wire logic [5:0]  portBDirIn,
   input  wire logic        lowSupplyDetector,
   input  wire logic        comparatorOut,
   // Core redirection and reset
   output logic             vectorValid,
   output logic      [10:0] vectorAddr,
   output logic             globalIrqEnable,
   output logic             wdtResetReq
);
   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   logic [IWU_NSRC-1:0] flag_reg, enable_reg;
   logic        run_reg, timeout_reg, prescToWdt_reg;
   logic [2:0]  prescSel_reg;
   logic [7:0]  wakeA_reg;
   logic [5:0]  wakeB_reg;
   logic        ext0Sel_reg, ext1Sel_reg, edgeSel_reg;
   logic [31:0] wdtCnt_reg;
   logic [7:0]  presc_reg;
   logic        gie_reg;

   // Synchronisers: first stage read only by second stage
   logic [15:0] syncA_reg, syncB_reg, prevIn_reg;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         syncA_reg <= 16'h0000;
         syncB_reg <= 16'h0000;
         prevIn_reg <= 16'h0000;
      end else begin
         syncA_reg <= {comparatorOut, lowSupplyDetector, portBPins, portAPins};
         syncB_reg <= syncA_reg;
         prevIn_reg <= syncB_reg;
      end
   end

   logic [7:0]  pinA, prevA;
   logic [5:0]  pinB, prevB;
   logic        lowV, prevLowV, cmpS;
   assign pinA = syncB_reg[7:0];
   assign pinB = syncB_reg[13:8];
   assign lowV = syncB_reg[14];
   assign cmpS = syncB_reg[15];
   assign prevA = prevIn_reg[7:0];
   assign prevB = prevIn_reg[13:8];
   assign prevLowV = prevIn_reg[14];

   // Previous timer counts for wrap detection
   logic [7:0] tA_reg;
   logic [9:0] tB_reg, tC_reg, tD_reg;
   logic       convDone_reg;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tA_reg <= 8'h00;
         tB_reg <= 10'h000;
         tC_reg <= 10'h000;
         tD_reg <= 10'h000;
         convDone_reg <= 1'b0;
      end else begin
         tA_reg <= timerACount;
         tB_reg <= timerBCount;
         tC_reg <= timerCCount;
         tD_reg <= timerDCount;
         convDone_reg <= converterDone;
      end
   end

   // -------------------------------------------------------------
   // APB decode
   // -------------------------------------------------------------
   logic wrEn, rdEn;
   assign wrEn = psel & penable & pwrite;
   assign rdEn = psel & penable & ~pwrite;

   // Comparator reference re-armed by oscillator register reads
   logic cmpRef_reg;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) cmpRef_reg <= 1'b0;
      else if (rdEn && paddr == IWU_OSC_OFF) cmpRef_reg <= cmpS;
   end

   // -------------------------------------------------------------
   // Event detection
   // -------------------------------------------------------------
   logic [IWU_NSRC-1:0] evt;
   logic [5:0]          bChangeMask;
   logic                wdtExpire, cmpArmed_reg;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) cmpArmed_reg <= 1'b0;
      else if (rdEn && paddr == IWU_OSC_OFF) cmpArmed_reg <= 1'b1;
      else if (cmpS != cmpRef_reg && cmpArmed_reg) cmpArmed_reg <= 1'b0;
   end
   always_comb begin
      bChangeMask = wakeB_reg & portBDirIn;
      bChangeMask[0] = bChangeMask[0] & ~ext0Sel_reg;
      bChangeMask[1] = bChangeMask[1] & ~ext1Sel_reg;
      evt = '0;
      evt[IWU_B_TMRA] = (tA_reg == IWU_TMR8_WRAP_FROM)
                        && (timerACount == 8'hff);
      evt[IWU_B_TMRB] = (tB_reg == IWU_TMR10_WRAP_FROM)
                        && (timerBCount == 10'h000);
      evt[IWU_B_TMRC] = (tC_reg == IWU_TMR10_WRAP_FROM)
                        && (timerCCount == 10'h000);
      evt[IWU_B_TMRD] = (tD_reg == IWU_TMR10_WRAP_FROM)
                        && (timerDCount == 10'h000);
      evt[IWU_B_PORT] = |(((pinA ^ prevA) & wakeA_reg & portADirIn))
                        | |((pinB ^ prevB) & bChangeMask);
      evt[IWU_B_EXT0] = ext0Sel_reg && (pinB[0] != prevB[0])
                        && (pinB[0] == edgeSel_reg);
      evt[IWU_B_EXT1] = ext1Sel_reg && (pinB[1] != prevB[1])
                        && (pinB[1] == edgeSel_reg);
      evt[IWU_B_WDOG] = wdtExpire && cfgWdtIrqMode;
      evt[IWU_B_LOWV] = prevLowV && !lowV;
      evt[IWU_B_CMP]  = cmpArmed_reg && (cmpS != cmpRef_reg);
      evt[IWU_B_CONV] = converterDone && !convDone_reg;
   end

   // -------------------------------------------------------------
   // Sticky flags: set wins over firmware clear
   // -------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) flag_reg <= '0;
      else if (wrEn && paddr == IWU_FLAG_OFF)
         flag_reg <= (flag_reg & pwdata[IWU_NSRC-1:0]) | evt;
      else
         flag_reg <= flag_reg | evt;
   end

   // Control registers written by software
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         enable_reg <= '0;
         run_reg <= 1'b0;
         prescToWdt_reg <= 1'b0;
         prescSel_reg <= 3'h0;
         wakeA_reg <= 8'h00;
         wakeB_reg <= 6'h00;
         ext0Sel_reg <= 1'b0;
         ext1Sel_reg <= 1'b0;
         edgeSel_reg <= 1'b0;
      end else if (wrEn) begin
         unique case (paddr)
            IWU_ENABLE_OFF: enable_reg <= pwdata[IWU_NSRC-1:0];
            IWU_POWER_CONTROL_REG_OFF:   run_reg <= pwdata[IWU_B_RUN];
            IWU_PRESC_OFF: begin
               prescToWdt_reg <= pwdata[3];
               prescSel_reg <= pwdata[2:0];
            end
            IWU_WAKE_OFF: begin
               wakeA_reg <= pwdata[7:0];
               wakeB_reg <= pwdata[13:8];
            end
            IWU_EXTCFG_OFF: begin
               ext0Sel_reg <= pwdata[0];
               ext1Sel_reg <= pwdata[1];
               edgeSel_reg <= pwdata[2];
            end
            default: ;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Watchdog
   // -------------------------------------------------------------
   function automatic int wdtLimit(input logic [1:0] sel);
      unique case (sel)
         2'd0: wdtLimit = WDT_CYC0;
         2'd1: wdtLimit = WDT_CYC1;
         2'd2: wdtLimit = WDT_CYC2;
         2'd3: wdtLimit = WDT_CYC3;
      endcase
   endfunction

   logic       wdtRun, wdtClear, baseTick;
   logic [8:0] prescDiv;
   assign wdtRun   = cfgWdtEnable & run_reg;
   assign wdtClear = clearWatchdogInstr & prescToWdt_reg;
   assign baseTick = wdtRun && (wdtCnt_reg == 32'(wdtLimit(cfgWdtPeriod) - 1));
   // Ratio 1:1..1:128 in reset mode, 1:2..1:256 in interrupt mode
   assign prescDiv = !prescToWdt_reg ? 9'd1
                   : 9'(9'd1 << ({1'b0, prescSel_reg} + {3'b000, cfgWdtIrqMode}));
   assign wdtExpire = baseTick && ({1'b0, presc_reg} == prescDiv - 9'd1);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wdtCnt_reg <= 32'h0000_0000;
         presc_reg <= 8'h00;
      end else if (wdtClear) begin
         wdtCnt_reg <= 32'h0000_0000;
         presc_reg <= 8'h00;
      end else if (wdtRun) begin
         wdtCnt_reg <= baseTick ? 32'h0000_0000 : wdtCnt_reg + 32'h1;
         if (baseTick) presc_reg <= wdtExpire ? 8'h00 : presc_reg + 8'h01;
      end
   end

   // Timeout indicator: expiry clears, clear-watchdog sets only while the prescaler is assigned to the watchdog
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) timeout_reg <= 1'b1;
      else if (wdtExpire) timeout_reg <= 1'b0;
      else if (wdtClear) timeout_reg <= 1'b1;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) wdtResetReq <= 1'b0;
      else wdtResetReq <= wdtExpire && !cfgWdtIrqMode;
   end

   // -------------------------------------------------------------
   // Global enable and vectoring
   // -------------------------------------------------------------
   logic hwPending;
   assign hwPending = |(flag_reg & enable_reg);
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         gie_reg <= 1'b0;
         vectorValid <= 1'b0;
         vectorAddr <= 11'h000;
      end else begin
         vectorValid <= 1'b0;
         if (swIrqInstr) begin
            gie_reg <= 1'b0;
            vectorValid <= 1'b1;
            vectorAddr <= IWU_SW_VECTOR;
         end else if (instrBoundary && gie_reg && hwPending) begin
            gie_reg <= 1'b0;
            vectorValid <= 1'b1;
            vectorAddr <= IWU_HW_VECTOR;
         end else if (enableIrqInstr || returnIrqInstr) begin
            gie_reg <= 1'b1;
         end else if (disableIrqInstr) begin
            gie_reg <= 1'b0;
         end
      end
   end
   assign globalIrqEnable = gie_reg;

   // -------------------------------------------------------------
   // APB read path, registered
   // -------------------------------------------------------------
   logic [31:0] rdData;
   logic        rdErr;
   always_comb begin
      rdData = 32'h0000_0000;
      rdErr = 1'b0;
      unique case (paddr)
         IWU_FLAG_OFF:   rdData[IWU_NSRC-1:0] = flag_reg & enable_reg;
         IWU_ENABLE_OFF: rdData[IWU_NSRC-1:0] = enable_reg;
         IWU_POWER_CONTROL_REG_OFF:   rdData[IWU_B_RUN] = run_reg;
         IWU_STATUS_OFF: rdData[IWU_B_TO] = timeout_reg;
         IWU_PRESC_OFF:  rdData[3:0] = {prescToWdt_reg, prescSel_reg};
         IWU_WAKE_OFF:   rdData[13:0] = {wakeB_reg, wakeA_reg};
         IWU_EXTCFG_OFF: rdData[2:0] = {edgeSel_reg, ext1Sel_reg, ext0Sel_reg};
         IWU_OSC_OFF:    rdData[0] = cmpS;
         default:        rdErr = 1'b1;
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & rdErr;
         if (psel && !penable && !pwrite) prdata <= rdData;
      end
   end
endmodule // iwu_unit

// *** iwu_unit_monitor.sv ***
// Purpose: Port-level checks on vectoring, global enable, APB and watchdog
// Assumes: Bound to every instance of iwu_unit
// Notes:   One clock domain, reset disables all checks
`timescale 1ns/1ps
module iwu_unit_chk
   import iwu_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        arst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        cfgWdtEnable,
   input wire logic        cfgWdtIrqMode,
   input wire logic        instrBoundary,
   input wire logic        swIrqInstr,
   input wire logic        enableIrqInstr,
   input wire logic        disableIrqInstr,
   input wire logic        returnIrqInstr,
   input wire logic        vectorValid,
   input wire logic [10:0] vectorAddr,
   input wire logic        globalIrqEnable,
   input wire logic        wdtResetReq
);
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_sw_vector: assert property (swIrqInstr |=> vectorValid && vectorAddr == IWU_SW_VECTOR)
      else $error("software vector missing");
   a_vec_gie_low: assert property (vectorValid |-> !globalIrqEnable)
      else $error("global enable high with vector");
   a_hw_vec_gated: assert property (vectorValid && !$past(swIrqInstr) |->
      vectorAddr == IWU_HW_VECTOR && $past(globalIrqEnable) && $past(instrBoundary))
      else $error("hardware vector without cause");
   a_eni_sets: assert property (enableIrqInstr && !swIrqInstr |=> globalIrqEnable || vectorValid)
      else $error("enable instruction ignored");
   a_reti_sets: assert property (returnIrqInstr && !swIrqInstr |=> globalIrqEnable || vectorValid)
      else $error("return did not set enable");
   a_disable_irq_instr_clears: assert property (disableIrqInstr && !enableIrqInstr && !returnIrqInstr
      |=> !globalIrqEnable) else $error("disable instruction ignored");
   a_gie_rise_cause: assert property ($rose(globalIrqEnable) |->
      $past(enableIrqInstr) || $past(returnIrqInstr)) else $error("enable rose alone");
   a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("ready not one access cycle");
   a_apb_unmapped: assert property (pready && paddr > IWU_OSC_OFF |-> pslverr)
      else $error("unmapped access not refused");
   a_wdt_mode: assert property (wdtResetReq |-> $past(cfgWdtEnable) && !$past(cfgWdtIrqMode))
      else $error("reset request in wrong mode");

   // Main scenarios reached
   c_hw_vector: cover property (vectorValid && vectorAddr == IWU_HW_VECTOR);
   c_wdt_reset: cover property (wdtResetReq);
   c_refused: cover property (pready && pslverr);
endmodule // iwu_unit_chk

bind iwu_unit iwu_unit_chk u_chk (
   .core_clk, .arst_n, .psel, .penable, .paddr, .pready, .pslverr, .cfgWdtEnable,
   .cfgWdtIrqMode, .instrBoundary, .swIrqInstr, .enableIrqInstr, .disableIrqInstr,
   .returnIrqInstr, .vectorValid, .vectorAddr, .globalIrqEnable, .wdtResetReq);

// *** tb_top.sv ***
// Purpose: Self-checking bench for the interrupt and watchdog unit
// Assumes: Shortened watchdog periods of 20, 40, 80 and 160 cycles
// Notes:   Registers reached over APB, core strobes from the core model
`timescale 1ns/1ps
module tb_top
   import iwu_pkg::*;
;
   localparam int C0 = 20;
   localparam int C1 = 40;
   logic        core_clk, arst_n, psel, penable, pwrite, pready, pslverr, perr;
   logic        cfgWdtEnable, cfgWdtIrqMode, converterDone, lowSupplyDetector;
   logic        comparatorOut, stall, vectorValid, globalIrqEnable, wdtResetReq;
   logic        instrBoundary, swIrq, eniInstr, disiInstr, retiInstr, clear_watchdog_instr;
   logic [1:0]  cfgWdtPeriod;
   logic [2:0]  opReq;
   logic [7:0]  paddr, timerACount, portAPins, vecCount;
   logic [5:0]  portBPins;
   logic [9:0]  timerBCount, timerCCount, timerDCount;
   logic [10:0] vectorAddr, lastVector;
   logic [31:0] pwdata, prdata, r;
   int          err_count, comparisons, d;

   iwu_unit #(.WDT_CYC0(C0), .WDT_CYC1(C1), .WDT_CYC2(80), .WDT_CYC3(160)) dut (
      .core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .cfgWdtEnable, .cfgWdtIrqMode, .cfgWdtPeriod, .instrBoundary,
      .swIrqInstr(swIrq), .enableIrqInstr(eniInstr), .disableIrqInstr(disiInstr),
      .returnIrqInstr(retiInstr), .clearWatchdogInstr(clear_watchdog_instr), .timerACount, .timerBCount,
      .timerCCount, .timerDCount, .converterDone, .portAPins, .portBPins,
      .portADirIn(8'hff), .portBDirIn(6'h3f), .lowSupplyDetector, .comparatorOut,
      .vectorValid, .vectorAddr, .globalIrqEnable, .wdtResetReq);

   iwu_core_model core (
      .core_clk, .arst_n, .stall, .opReq, .vectorValid, .vectorAddr, .instrBoundary,
      .swIrqInstr(swIrq), .enableIrqInstr(eniInstr), .disableIrqInstr(disiInstr),
      .returnIrqInstr(retiInstr), .clearWatchdogInstr(clear_watchdog_instr), .lastVector, .vecCount);

   // ------------------------------------------------------------
   // Clock, checking and bus tasks
   // ------------------------------------------------------------
   initial core_clk = 1'b0;
   always #5 core_clk = ~core_clk;

   task automatic report_and_stop;
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Setup, access until ready, release; cd raises converterDone at access
   task automatic apb(logic w, logic [7:0] a, logic [31:0] wd, logic cd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      converterDone <= cd;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n == 20) err_count++;
      r = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] wd);
      apb(1'b1, a, wd, 1'b0);
   endtask

   task automatic rd(string nm, logic [7:0] a, logic [31:0] e);
      apb(1'b0, a, 32'h0, converterDone);
      chk(nm, r, e);
   endtask

   task automatic op(logic [2:0] c);
      opReq <= c;
      @(posedge core_clk);
      opReq <= 3'h0;
      repeat (3) @(posedge core_clk);
   endtask

   // Cycles up to the next watchdog reset request
   task automatic wait_rst;
      d = 0;
      do begin
         @(posedge core_clk);
         d++;
      end while (wdtResetReq !== 1'b1 && d < 2000);
   endtask

   task automatic period(logic [31:0] e);
      wait_rst();
      wait_rst();
      chk("wdt period", (d >= e - 1 && d <= e + 1), 32'h1);
   endtask

   // Hang guard
   initial begin
      #100000;
      err_count++;
      report_and_stop();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {arst_n, psel, penable, pwrite, converterDone, comparatorOut, stall} = 7'h0;
      {cfgWdtEnable, cfgWdtIrqMode, lowSupplyDetector} = 3'h7;
      {paddr, pwdata, opReq, cfgWdtPeriod, portAPins, portBPins} = '0;
      {timerACount, timerBCount, timerCCount, timerDCount} = {8'h01, 30'h0};
      err_count = 0;
      comparisons = 0;
      repeat (8) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      rd("status", IWU_STATUS_OFF, 32'h10);
      rd("unmapped", 8'h20, 32'h0);
      chk("unmapped err", {31'h0, perr}, 32'h1);
      wr(IWU_ENABLE_OFF, 32'h7ff);
      wr(IWU_WAKE_OFF, 32'h400);
      {timerACount, timerBCount, timerCCount, timerDCount} <= {8'h00, {3{10'h3ff}}};
      @(posedge core_clk);
      {timerACount, timerBCount, timerCCount, timerDCount} <= {8'hff, 30'h0};
      {converterDone, lowSupplyDetector, portBPins[2]} <= 3'b101;
      repeat (5) @(posedge core_clk);
      rd("flags", IWU_FLAG_OFF, 32'h51f);
      converterDone <= 1'b0;
      wr(IWU_ENABLE_OFF, 32'h00f);
      rd("masked", IWU_FLAG_OFF, 32'h00f);
      wr(IWU_ENABLE_OFF, 32'h7ff);
      wr(IWU_FLAG_OFF, 32'h7fe);
      rd("one clear", IWU_FLAG_OFF, 32'h51e);
      wr(IWU_FLAG_OFF, 32'h0);
      apb(1'b1, IWU_FLAG_OFF, 32'h0, 1'b1);
      rd("event wins", IWU_FLAG_OFF, 32'h400);
      wr(IWU_FLAG_OFF, 32'h0);
      wr(IWU_EXTCFG_OFF, 32'h7);
      wr(IWU_WAKE_OFF, 32'h300);
      portBPins[1:0] <= 2'b11;
      repeat (5) @(posedge core_clk);
      rd("ext", IWU_FLAG_OFF, 32'h0a0);
      rd("osc", IWU_OSC_OFF, 32'h0);
      {converterDone, comparatorOut} <= 2'b01;
      repeat (5) @(posedge core_clk);
      rd("cmp", IWU_FLAG_OFF, 32'h2a0);
      wr(IWU_FLAG_OFF, 32'h0);
      // Vectoring with a pending timer flag
      timerACount <= 8'h00;
      @(posedge core_clk);
      timerACount <= 8'hff;
      repeat (5) @(posedge core_clk);
      chk("no vector", {24'h0, vecCount}, 32'h0);
      stall <= 1'b1;
      op(3'h2);
      chk("stalled", {24'h0, vecCount}, 32'h0);
      chk("gie set", {31'h0, globalIrqEnable}, 32'h1);
      stall <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk("hw vector", {21'h0, lastVector}, {21'h0, IWU_HW_VECTOR});
      chk("gie hw", {31'h0, globalIrqEnable}, 32'h0);
      wr(IWU_FLAG_OFF, 32'h0);
      repeat (12) @(posedge core_clk);
      chk("gie reti", {31'h0, globalIrqEnable}, 32'h1);
      op(3'h1);
      chk("sw vector", {21'h0, lastVector}, {21'h0, IWU_SW_VECTOR});
      chk("gie sw", {31'h0, globalIrqEnable}, 32'h0);
      repeat (14) @(posedge core_clk);
      chk("vectors", {24'h0, vecCount}, 32'h2);
      op(3'h3);
      chk("gie disable_irq_instr", {31'h0, globalIrqEnable}, 32'h0);
      // Watchdog in interrupt mode, then reset mode
      repeat (40) @(posedge core_clk);
      rd("stopped", IWU_FLAG_OFF, 32'h0);
      wr(IWU_POWER_CONTROL_REG_OFF, 32'h80);
      repeat (30) @(posedge core_clk);
      rd("wdt flag", IWU_FLAG_OFF, 32'h40);
      rd("timeout", IWU_STATUS_OFF, 32'h0);
      wr(IWU_PRESC_OFF, 32'h8);
      op(3'h4);
      rd("cleared", IWU_STATUS_OFF, 32'h10);
      wr(IWU_POWER_CONTROL_REG_OFF, 32'h0);
      {cfgWdtIrqMode, cfgWdtPeriod} <= 3'h1;
      wr(IWU_PRESC_OFF, 32'h0);
      wr(IWU_POWER_CONTROL_REG_OFF, 32'h80);
      period(C1);
      wr(IWU_PRESC_OFF, 32'hb);
      period(8 * C1);
      // Widest interrupt-mode ratio 1:256 on the 20-cycle base period
      wr(IWU_POWER_CONTROL_REG_OFF, 32'h0);
      wr(IWU_FLAG_OFF, 32'h0);
      {cfgWdtIrqMode, cfgWdtPeriod} <= 3'h4;
      wr(IWU_PRESC_OFF, 32'hf);
      op(3'h4);
      wr(IWU_POWER_CONTROL_REG_OFF, 32'h80);
      repeat (5000) @(posedge core_clk);
      rd("ratio early", IWU_FLAG_OFF, 32'h0);
      repeat (200) @(posedge core_clk);
      rd("ratio 256", IWU_FLAG_OFF, 32'h40);
      report_and_stop();
   end
endmodule // tb_top
